// >>> hdl/vcc_pkg.sv
// Purpose: shared constants of the oscillator tune controller
// Assumes: byte-wide register port, 8-bit register offsets
// Notes: settle counts grow by doubling with the select code
package vcc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int TRIM_W = 7;
    localparam int SEL_W = 3;
    localparam int BIT_W = 3;
    localparam int CNT_W = 12;

    localparam logic [ADDR_W-1:0] ADDR_TRIM = 8'h59;
    localparam logic [ADDR_W-1:0] ADDR_HOLD = 8'h5c;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h5d;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h5e;

    localparam int TRIM_LSB = 0;
    localparam int HOLD_BIT = 0;
    localparam int ENABLE_BIT = 0;
    localparam int SEL_LSB = 4;
    localparam int DONE_BIT = 0;

    localparam logic [TRIM_W-1:0] TRIM_RESET = 7'h00;
    localparam logic [TRIM_W-1:0] TRIM_MID = 7'h40;
    localparam logic [SEL_W-1:0] SEL_RESET = 3'h4;
    localparam logic [BIT_W-1:0] BIT_TOP = 3'h6;

    // clock rate and the shortest settle wait
    localparam int CLOCK_HZ = 25_000_000;
    localparam int SETTLE_BASE_NS = 640;
    localparam int SETTLE_BASE_CYC =
        (SETTLE_BASE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {
        VCC_IDLE,
        VCC_SETTLE,
        VCC_DECIDE
    } vcc_state_t;
endpackage

// >>> hdl/vcc_settle_timer.sv
// Purpose: settle wait timer for the oscillator tune engine
// Assumes: start is a one-cycle pulse from the same clock
// Notes: wait is BASE << select cycles, so it doubles per code
`timescale 1ns/100ps
`default_nettype none
module vcc_settle_timer #(
    parameter int BASE = vcc_pkg::SETTLE_BASE_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // control
    input wire logic start,
    input wire logic [vcc_pkg::SEL_W-1:0] select,
    // status
    output logic expired
);
    import vcc_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic running;
    logic next_running;
    logic next_expired;
    logic [CNT_W-1:0] load;

    // longer wait for a larger code
    assign load = CNT_W'((BASE << select) - 1);

    always_comb begin
        next_count = count;
        next_running = running;
        next_expired = expired;
        if (start) begin
            next_count = load;
            next_running = 1'b1;
            next_expired = 1'b0;
        end else if (running) begin
            if (count == '0) begin
                next_running = 1'b0;
                next_expired = 1'b1;
            end else begin
                next_count = count - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (clk_en) begin
            count <= next_count;
            running <= next_running;
            expired <= next_expired;
        end
    end

    AST_SETTLE_MIN: assert property (
        @(posedge clock) disable iff (rst)
        start && clk_en |=> !expired [*8]
    ) else $error("settle wait ended too early");

    AST_SETTLE_LOAD: assert property (
        @(posedge clock) disable iff (rst)
        start && clk_en && select == 3'h0 |=>
        (!expired && running) [*8]
    ) else $error("settle timer not running after start");
endmodule
`default_nettype wire

// >>> hdl/vcc_tune_ctrl.sv
// Purpose: oscillator trim calibration with its control registers
// Assumes: osc_above_target comes from the analog loop, asynchronous
// Notes: binary search of the trim code, msb first
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - 7-bit trim code at 0x59 bits 6:0, written by engine or software
// - settle wait from bits 6:4 after each trial bit is set in tuning
// - tuning starts when hold is cleared and the engine is enabled
// - engine adjusts trim by itself to centre the oscillator
// - done flag reads 1 after tuning or when tuning is skipped
module vcc_tune_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // register port
    input wire logic [vcc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [vcc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [vcc_pkg::DATA_W-1:0] reg_rdata,
    // oscillator side
    input wire logic osc_above_target,
    output logic [vcc_pkg::TRIM_W-1:0] oscillator_trim_code,
    output logic synth_program_hold,
    output logic tune_busy
);
    import vcc_pkg::*;

    vcc_state_t state;
    vcc_state_t next_state;
    logic [BIT_W-1:0] bit_idx;
    logic [BIT_W-1:0] next_bit_idx;
    logic [TRIM_W-1:0] next_trim;
    logic next_hold;
    logic tune_engine_enable;
    logic next_enable;
    logic [SEL_W-1:0] tune_settle_select;
    logic [SEL_W-1:0] next_select;
    logic tune_done_flag;
    logic next_done;
    logic next_busy;
    logic [DATA_W-1:0] next_rdata;
    logic settle_start;
    logic settle_done;
    logic osc_meta;
    logic osc_fast;
    logic hold_release;

    // strobe and address are arguments so callers see every change
    function automatic logic hit(
        input logic we,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] a
    );
        hit = we && addr == a;
    endfunction

    // two-flop synchroniser for the comparator
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            osc_meta <= 1'b0;
            osc_fast <= 1'b0;
        end else if (clk_en) begin
            osc_meta <= osc_above_target;
            osc_fast <= osc_meta;
        end
    end

    assign hold_release = hit(reg_write, reg_addr, ADDR_HOLD)
        && !reg_wdata[HOLD_BIT] && synth_program_hold;

    vcc_settle_timer u_timer (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .start(settle_start),
        .select(tune_settle_select),
        .expired(settle_done)
    );

    always_comb begin
        next_state = state;
        next_bit_idx = bit_idx;
        next_trim = oscillator_trim_code;
        next_hold = synth_program_hold;
        next_enable = tune_engine_enable;
        next_select = tune_settle_select;
        next_done = tune_done_flag;
        settle_start = 1'b0;
        if (hit(reg_write, reg_addr, ADDR_HOLD)) begin
            next_hold = reg_wdata[HOLD_BIT];
        end
        if (hit(reg_write, reg_addr, ADDR_CTRL)) begin
            next_enable = reg_wdata[ENABLE_BIT];
            next_select = reg_wdata[SEL_LSB +: SEL_W];
        end
        unique case (state)
            VCC_IDLE: begin
                if (hit(reg_write, reg_addr, ADDR_TRIM)) begin
                    next_trim = reg_wdata[TRIM_LSB +: TRIM_W];
                end
                if (synth_program_hold) begin
                    next_done = 1'b0;
                end
                if (hold_release && tune_engine_enable) begin
                    next_state = VCC_SETTLE;
                    next_trim = TRIM_MID;
                    next_bit_idx = BIT_TOP;
                    next_done = 1'b0;
                    settle_start = 1'b1;
                end else if (!next_hold && !tune_engine_enable) begin
                    next_done = 1'b1;
                end
            end
            VCC_SETTLE: begin
                if (settle_done) begin
                    next_state = VCC_DECIDE;
                end
            end
            VCC_DECIDE: begin
                if (osc_fast) begin
                    next_trim[bit_idx] = 1'b0;
                end
                if (bit_idx == '0) begin
                    next_state = VCC_IDLE;
                    next_done = 1'b1;
                end else begin
                    next_bit_idx = bit_idx - BIT_W'(1);
                    next_trim[bit_idx - BIT_W'(1)] = 1'b1;
                    next_state = VCC_SETTLE;
                    settle_start = 1'b1;
                end
            end
        endcase
        // hold restarts the synthesizer and aborts a running search
        if (next_hold && state != VCC_IDLE) begin
            next_state = VCC_IDLE;
            next_done = 1'b0;
        end
        next_busy = next_state != VCC_IDLE;
    end

    always_comb begin
        next_rdata = reg_rdata;
        if (reg_read) begin
            next_rdata = '0;
            unique case (reg_addr)
                ADDR_TRIM: next_rdata[TRIM_LSB +: TRIM_W] =
                    oscillator_trim_code;
                ADDR_HOLD: next_rdata[HOLD_BIT] = synth_program_hold;
                ADDR_CTRL: begin
                    next_rdata[ENABLE_BIT] = tune_engine_enable;
                    next_rdata[SEL_LSB +: SEL_W] = tune_settle_select;
                end
                ADDR_STATUS: next_rdata[DONE_BIT] = tune_done_flag;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= VCC_IDLE;
            bit_idx <= '0;
            oscillator_trim_code <= TRIM_RESET;
            synth_program_hold <= 1'b0;
            tune_engine_enable <= 1'b0;
            tune_settle_select <= SEL_RESET;
            tune_done_flag <= 1'b0;
            tune_busy <= 1'b0;
            reg_rdata <= '0;
        end else if (clk_en) begin
            state <= next_state;
            bit_idx <= next_bit_idx;
            oscillator_trim_code <= next_trim;
            synth_program_hold <= next_hold;
            tune_engine_enable <= next_enable;
            tune_settle_select <= next_select;
            tune_done_flag <= next_done;
            tune_busy <= next_busy;
            reg_rdata <= next_rdata;
        end
    end

    AST_TRIM_WRITE: assert property (
        @(posedge clock) disable iff (rst)
        clk_en && state == VCC_IDLE
            && hit(reg_write, reg_addr, ADDR_TRIM) && !hold_release
        |=> oscillator_trim_code == $past(reg_wdata[6:0])
    ) else $error("trim write not stored");

    AST_TRIM_READ: assert property (
        @(posedge clock) disable iff (rst)
        clk_en && reg_read && reg_addr == ADDR_TRIM
        |=> reg_rdata == {1'b0, $past(oscillator_trim_code)}
    ) else $error("trim readback wrong");

    AST_START: assert property (
        @(posedge clock) disable iff (rst)
        clk_en && state == VCC_IDLE && hold_release && tune_engine_enable
        |=> state == VCC_SETTLE && oscillator_trim_code == 7'h40
            && !tune_done_flag
    ) else $error("tuning did not start on hold release");

    AST_SETTLE_AFTER_CHANGE: assert property (
        @(posedge clock) disable iff (rst)
        clk_en && state == VCC_DECIDE && bit_idx != 3'h0 && !next_hold
        |=> (state == VCC_SETTLE || synth_program_hold) [*5]
    ) else $error("trim changed without a settle wait");

    AST_DECIDE_CLEAR: assert property (
        @(posedge clock) disable iff (rst)
        clk_en && state == VCC_DECIDE && osc_fast
        |=> !oscillator_trim_code[$past(bit_idx)]
    ) else $error("trial bit kept while oscillator fast");

    AST_FINISH: assert property (
        @(posedge clock) disable iff (rst)
        clk_en && state == VCC_DECIDE && bit_idx == 3'h0 && !next_hold
        |=> tune_done_flag && state == VCC_IDLE && !tune_busy
    ) else $error("done flag missing after last step");

    AST_SKIP: assert property (
        @(posedge clock) disable iff (rst)
        clk_en && state == VCC_IDLE && !synth_program_hold
            && !tune_engine_enable && !reg_write
        |=> tune_done_flag
    ) else $error("skipped tuning not flagged done");

    AST_BUSY_NOT_DONE: assert property (
        @(posedge clock) disable iff (rst)
        tune_busy |-> !tune_done_flag && state != VCC_IDLE
    ) else $error("done flag set while tuning");

    AST_FREEZE: assert property (
        @(posedge clock) disable iff (rst)
        !clk_en |=> $stable(oscillator_trim_code) && $stable(state)
    ) else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// >>> tb/test_vcc_tune_ctrl.sv
// Purpose: self-checking bench for the oscillator tune controller
// Assumes: clk_en high except in the freeze scenario, comparator from target
// Notes: durations of tuning are compared only for growth with select
`timescale 1ns/100ps
`default_nettype none
module test_vcc_tune_ctrl;
    import vcc_pkg::*;
    logic clock;
    logic rst;
    logic clk_en;
    logic reg_write;
    logic reg_read;
    logic osc_above_target;
    logic synth_program_hold;
    logic tune_busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] got;
    logic [TRIM_W-1:0] oscillator_trim_code;
    logic [TRIM_W-1:0] target;
    int n_mismatch;
    int checks_done;
    int cycles;
    int tick;
    int d0;
    int d1;
    int d2;

    // oscillator runs fast whenever the trim is above the target code
    assign osc_above_target = oscillator_trim_code > target;

    vcc_tune_ctrl dut_u (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .osc_above_target(osc_above_target),
        .oscillator_trim_code(oscillator_trim_code),
        .synth_program_hold(synth_program_hold),
        .tune_busy(tune_busy)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge clock);
        #1;
        reg_read = 1'b0;
        got = reg_rdata;
    endtask

    task automatic reset_values();
        rd(ADDR_TRIM);
        chk(got, 8'h00);
        rd(ADDR_HOLD);
        chk(got, 8'h00);
        rd(ADDR_CTRL);
        chk(got, 8'h40);
        rd(ADDR_STATUS);
        chk(got, 8'h01);
        rd(8'h5a);
        chk(got, 8'h00);
    endtask

    task automatic reg_access();
        wr(ADDR_TRIM, 8'h25);
        chk({1'b0, oscillator_trim_code}, 8'h25);
        rd(ADDR_TRIM);
        chk(got, 8'h25);
        wr(ADDR_HOLD, 8'h01);
        chk({7'h00, synth_program_hold}, 8'h01);
        wr(ADDR_CTRL, 8'h71);
        rd(ADDR_CTRL);
        chk(got, 8'h71);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS);
        chk(got, 8'h00);
    endtask

    task automatic run_cal(input logic [2:0] sel, input logic [6:0] tgt);
        target = tgt;
        wr(ADDR_HOLD, 8'h01);
        wr(ADDR_CTRL, {1'b0, sel, 4'h1});
        wr(ADDR_HOLD, 8'h00);
        chk({7'h00, tune_busy}, 8'h01);
        chk({1'b0, oscillator_trim_code}, 8'h40);
        cycles = 0;
        while (tune_busy === 1'b1 && cycles < 5000) begin
            @(posedge clock);
            #1;
            cycles++;
        end
        chk({7'h00, tune_busy}, 8'h00);
        rd(ADDR_STATUS);
        chk(got, 8'h01);
        chk({1'b0, oscillator_trim_code}, {1'b0, tgt});
        rd(ADDR_TRIM);
        chk(got, {1'b0, tgt});
    endtask

    task automatic skip_and_abort();
        wr(ADDR_HOLD, 8'h01);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_HOLD, 8'h00);
        chk({7'h00, tune_busy}, 8'h00);
        rd(ADDR_STATUS);
        chk(got, 8'h01);
        chk({1'b0, oscillator_trim_code}, 8'h7f);
        wr(ADDR_HOLD, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_HOLD, 8'h00);
        repeat (30) @(posedge clock);
        wr(ADDR_HOLD, 8'h01);
        chk({7'h00, tune_busy}, 8'h00);
        rd(ADDR_STATUS);
        chk(got, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_TRIM, 8'h12);
        chk({1'b0, oscillator_trim_code}, 8'h12);
    endtask

    // clock enable low mid-search must freeze trim and busy
    task automatic freeze_check();
        target = 7'h2a;
        wr(ADDR_HOLD, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_HOLD, 8'h00);
        repeat (25) @(posedge clock);
        #1;
        chk({1'b0, oscillator_trim_code}, 8'h20);
        clk_en = 1'b0;
        repeat (40) @(posedge clock);
        #1;
        chk({1'b0, oscillator_trim_code}, 8'h20);
        chk({7'h00, tune_busy}, 8'h01);
        clk_en = 1'b1;
        cycles = 0;
        while (tune_busy === 1'b1 && cycles < 5000) begin
            @(posedge clock);
            #1;
            cycles++;
        end
        rd(ADDR_STATUS);
        chk(got, 8'h01);
        chk({1'b0, oscillator_trim_code}, 8'h2a);
    endtask

    // cut a hang short
    always @(posedge clock) begin
        tick++;
        if (tick == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        tick = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        target = 7'h00;
        repeat (6) @(posedge clock);
        #1;
        rst = 1'b0;
        reset_values();
        reg_access();
        run_cal(3'h0, 7'h00);
        d0 = cycles;
        run_cal(3'h1, 7'h35);
        d1 = cycles;
        run_cal(3'h2, 7'h7f);
        d2 = cycles;
        chk({7'h00, d1 > d0}, 8'h01);
        chk({7'h00, d2 > d1}, 8'h01);
        skip_and_abort();
        freeze_check();
        end_sim();
    end
endmodule
`default_nettype wire
